//--- rtl/ppdc_cfg.svh
// Constants for the charge pump, oscillator and alignment DAC decoder.
// Assumes a 160-bit control word held as five 32-bit bus words.
`ifndef PPDC_CFG_SVH
`define PPDC_CFG_SVH

// ------------------------------------------------------------
// Register map, byte offsets and word indexes
// ------------------------------------------------------------
`define PPDC_OFF_WORD0      8'h00
`define PPDC_OFF_CTRL       8'h14
`define PPDC_OFF_STATUS     8'h18
`define PPDC_NUM_WORDS      5
`define PPDC_IDX_CTRL       6'h05
`define PPDC_IDX_STATUS     6'h06
`define PPDC_CTRL_LOAD      0
`define PPDC_STAT_PUMP_HIGH 0
`define PPDC_STAT_CHANGE    1
`define PPDC_STAT_LOADED    2
`define PPDC_WORD_RESET     160'h0

// ------------------------------------------------------------
// Control word bit positions
// ------------------------------------------------------------
`define PPDC_B_DLY_SEL      18
`define PPDC_B_DLY1_LO      20
`define PPDC_B_DLY2_LO      22
`define PPDC_B_OFS_A_LO     24
`define PPDC_B_NO_SHIFT     32
`define PPDC_B_GAIN_A_LO    38
`define PPDC_B_OFS_B_LO     52
`define PPDC_B_WIRE         60
`define PPDC_B_IMPULSE      61
`define PPDC_B_HIGH_2MA     62
`define PPDC_B_LOW_100UA    63
`define PPDC_B_OSC_BUF      64
`define PPDC_B_OSC_ON       65
`define PPDC_B_GAIN_B_LO    66
`define PPDC_B_NO_FRAC      144

`endif

//--- rtl/ppdc_pkg.sv
// Types for the charge pump, oscillator and alignment DAC decoder.
// Assumes ppdc_cfg.svh is on the include path.
package ppdc_pkg;

  // ------------------------------------------------------------
  // Decoded analog settings
  // ------------------------------------------------------------
  typedef struct packed {
    logic       wire_spur_switch;
    logic       impulse_spur_correction;
    logic       high_pump_2ma;
    logic       low_pump_100ua;
    logic       high_pump_delay_select;
    logic [1:0] high_pump_delay;
    logic       high_pump_enabled;
    logic       osc_on;
    logic       osc_buffer_out;
    logic       osc_buffer_in;
    logic       am_loop_filter_ext;
    logic [7:0] align_dac_a_gain;
    logic [6:0] align_dac_a_offset;
    logic [7:0] align_dac_b_gain;
    logic [6:0] align_dac_b_offset;
  } ppdc_cfg_s;

  typedef logic [159:0] ppdc_word_t;

endpackage

//--- rtl/ppdc_top.sv
// Control word staging and decoding for pump, oscillator and alignment DACs.
// Assumes a classic Wishbone master and a frequency change level from the PLL.
//
// Behaviour
// - Spur suppression switches act only with fractional and direct shift both active.
// - Bit 60 set enables wire spur switch, cleared disables it.
// - Bit 61 set enables impulse correction pump, cleared disables it.
// - High current pump during frequency change, low current pump afterwards.
// - Selected delay bits both zero: high pump never on, low pump only.
// - Bit 62 picks high pump 1 mA when 0, 2 mA when 1.
// - Bit 63 picks low pump 50 uA when 0, 100 uA when 1.
// - Bit 65 zero: oscillator off, buffer input, AM filter pin external.
// - Bit 65 one: oscillator on, bit 64 picks buffer off or output.
// - First DAC gain is bits 38 to 45, LSB at 38.
// - Second DAC gain is bits 66 to 73, LSB at 66.
// - Gain code is monotonic unsigned over 255 steps.
// - First DAC offset is bits 24 to 30, LSB at 24.
// - Second DAC offset is bits 52 to 58, LSB at 52.
// - Offset code is unsigned over 127 steps, 64 near zero.
// - Fractional active when bit 144 zero, shift active when bit 32 zero.
// - Bit 18 picks first delay register at 0, second at 1.
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "ppdc_cfg.svh"

module ppdc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [ADDR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output      logic [31:0]       WB_DAT_O,
  output      logic              WB_ACK_O,
  input  wire logic              FREQ_CHANGE,
  output      ppdc_pkg::ppdc_cfg_s SETTINGS,
  output      logic              PUMP_HIGH,
  output      logic              PUMP_LOW
);
  import ppdc_pkg::*;

  // ------------------------------------------------------------
  // Decode of the control word
  // ------------------------------------------------------------
  function automatic ppdc_cfg_s decode(input ppdc_word_t w);
    ppdc_cfg_s c;
    logic      spur_ok;
    c       = '0;
    spur_ok = !w[`PPDC_B_NO_FRAC] && !w[`PPDC_B_NO_SHIFT];
    c.wire_spur_switch        = spur_ok && w[`PPDC_B_WIRE];
    c.impulse_spur_correction = spur_ok && w[`PPDC_B_IMPULSE];
    c.high_pump_2ma           = w[`PPDC_B_HIGH_2MA];
    c.low_pump_100ua          = w[`PPDC_B_LOW_100UA];
    c.high_pump_delay_select  = w[`PPDC_B_DLY_SEL];
    c.high_pump_delay         = w[`PPDC_B_DLY_SEL] ? w[`PPDC_B_DLY2_LO +: 2]
                                                   : w[`PPDC_B_DLY1_LO +: 2];
    c.high_pump_enabled       = |c.high_pump_delay;
    c.osc_on                  = w[`PPDC_B_OSC_ON];
    c.osc_buffer_in           = !w[`PPDC_B_OSC_ON];
    c.am_loop_filter_ext      = !w[`PPDC_B_OSC_ON];
    c.osc_buffer_out          = w[`PPDC_B_OSC_ON] && w[`PPDC_B_OSC_BUF];
    c.align_dac_a_gain        = w[`PPDC_B_GAIN_A_LO +: 8];
    c.align_dac_b_gain        = w[`PPDC_B_GAIN_B_LO +: 8];
    c.align_dac_a_offset      = w[`PPDC_B_OFS_A_LO +: 7];
    c.align_dac_b_offset      = w[`PPDC_B_OFS_B_LO +: 7];
    return c;
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  ppdc_word_t  stage;
  logic        loaded;
  logic        change_seen;
  wire  [5:0]  idx       = 6'(WB_ADR_I[ADDR_W-1:2]);
  wire         req       = WB_CYC_I && WB_STB_I;
  wire         wr_take   = req && WB_WE_I && WB_ACK_O;
  wire         hit_word  = idx < 6'(`PPDC_NUM_WORDS);
  wire         load      = wr_take && idx == `PPDC_IDX_CTRL
                           && WB_SEL_I[0] && WB_DAT_I[`PPDC_CTRL_LOAD];
  wire  [31:0] word_rd   = hit_word ? stage[idx[2:0]*32 +: 32] : 32'h0;
  wire  [31:0] status_rd = {29'h0, loaded, change_seen, PUMP_HIGH};
  wire  [31:0] rd_mux    = hit_word ? word_rd
                         : (idx == `PPDC_IDX_STATUS) ? status_rd : 32'h0;
  wire         next_pump = FREQ_CHANGE && SETTINGS.high_pump_enabled;

  // ------------------------------------------------------------
  // Bus answer, one wait cycle
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= req && !WB_ACK_O;
      WB_DAT_O <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Staging word, byte writes
  // ------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < `PPDC_NUM_WORDS * 4; gb++) begin : g_byte
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          stage[gb*8 +: 8] <= 8'h0;
        end else if (wr_take && hit_word && idx == 6'(gb / 4) && WB_SEL_I[gb % 4]) begin
          stage[gb*8 +: 8] <= WB_DAT_I[(gb % 4)*8 +: 8];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Take over of a whole word
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      SETTINGS <= decode(`PPDC_WORD_RESET);
      loaded   <= 1'b0;
    end else if (load) begin
      SETTINGS <= decode(stage);
      loaded   <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Charge pump selection
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      PUMP_HIGH   <= 1'b0;
      PUMP_LOW    <= 1'b1;
      change_seen <= 1'b0;
    end else begin
      PUMP_HIGH   <= next_pump;
      PUMP_LOW    <= !next_pump;
      change_seen <= FREQ_CHANGE;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_change_start;
    FREQ_CHANGE && SETTINGS.high_pump_enabled;
  endsequence

  sequence s_change_end;
    !FREQ_CHANGE;
  endsequence

  sequence s_pump_high;
    PUMP_HIGH && !PUMP_LOW;
  endsequence

  sequence s_pump_low;
    PUMP_LOW && !PUMP_HIGH;
  endsequence

  sequence s_read_req;
    req && !WB_WE_I && !WB_ACK_O;
  endsequence

  sequence s_write_req;
    req && WB_WE_I && !WB_ACK_O;
  endsequence

  a_wire_switch: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load |=> SETTINGS.wire_spur_switch == ($past(stage[`PPDC_B_WIRE])
      && !$past(stage[`PPDC_B_NO_FRAC]) && !$past(stage[`PPDC_B_NO_SHIFT])))
    else $error("wire spur switch mismatch");

  a_impulse_corr: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load |=> SETTINGS.impulse_spur_correction == ($past(stage[`PPDC_B_IMPULSE])
      && !$past(stage[`PPDC_B_NO_FRAC]) && !$past(stage[`PPDC_B_NO_SHIFT])))
    else $error("impulse correction mismatch");

  a_pump_change: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_change_start ##1 s_change_end |-> s_pump_high ##1 s_pump_low)
    else $error("pump did not go high then low");

  a_pump_off: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !SETTINGS.high_pump_enabled |=> !PUMP_HIGH && PUMP_LOW)
    else $error("high pump on while disabled");

  a_delay_select: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load |=> SETTINGS.high_pump_enabled == ($past(stage[`PPDC_B_DLY_SEL])
      ? |$past(stage[`PPDC_B_DLY2_LO +: 2]) : |$past(stage[`PPDC_B_DLY1_LO +: 2])))
    else $error("delay register select mismatch");

  a_pump_levels: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load |=> SETTINGS.high_pump_2ma == $past(stage[`PPDC_B_HIGH_2MA])
      && SETTINGS.low_pump_100ua == $past(stage[`PPDC_B_LOW_100UA]))
    else $error("pump magnitude mismatch");

  a_osc_off: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load && !stage[`PPDC_B_OSC_ON] |=> !SETTINGS.osc_on && SETTINGS.osc_buffer_in
      && SETTINGS.am_loop_filter_ext && !SETTINGS.osc_buffer_out)
    else $error("oscillator off mode wrong");

  a_osc_std: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load && stage[`PPDC_B_OSC_ON] |=> SETTINGS.osc_on && !SETTINGS.osc_buffer_in
      && !SETTINGS.am_loop_filter_ext
      && SETTINGS.osc_buffer_out == $past(stage[`PPDC_B_OSC_BUF]))
    else $error("oscillator standard mode wrong");

  a_gain_codes: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load |=> SETTINGS.align_dac_a_gain == $past(stage[`PPDC_B_GAIN_A_LO +: 8])
      && SETTINGS.align_dac_b_gain == $past(stage[`PPDC_B_GAIN_B_LO +: 8]))
    else $error("gain code mismatch");

  a_offset_codes: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load |=> SETTINGS.align_dac_a_offset == $past(stage[`PPDC_B_OFS_A_LO +: 7])
      && SETTINGS.align_dac_b_offset == $past(stage[`PPDC_B_OFS_B_LO +: 7]))
    else $error("offset code mismatch");

  a_hold_word: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !load |=> $stable(SETTINGS))
    else $error("settings changed without take over");

  a_ack_pulse: assert property (@(posedge CLOCK) disable iff (!RST_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");

  a_pump_rise: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_change_start |=> s_pump_high)
    else $error("high pump not on during change");

  a_pump_fall: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_change_end |=> s_pump_low)
    else $error("low pump not on after change");

  a_pump_inverse: assert property (@(posedge CLOCK) disable iff (!RST_N)
    PUMP_LOW == !PUMP_HIGH)
    else $error("pump levels not exclusive");

  a_pump_low_only: assert property (@(posedge CLOCK) disable iff (!RST_N)
    FREQ_CHANGE && !SETTINGS.high_pump_enabled |=> s_pump_low)
    else $error("high pump on with delay off");

  a_spur_gate: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load && (stage[`PPDC_B_NO_FRAC] || stage[`PPDC_B_NO_SHIFT])
      |=> !SETTINGS.wire_spur_switch && !SETTINGS.impulse_spur_correction)
    else $error("spur switch on outside fractional shift");

  a_buffer_excl: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !(SETTINGS.osc_buffer_in && SETTINGS.osc_buffer_out))
    else $error("buffer input and output together");

  a_osc_filter: assert property (@(posedge CLOCK) disable iff (!RST_N)
    SETTINGS.osc_on == !SETTINGS.am_loop_filter_ext)
    else $error("filter pin mode mismatch");

  a_osc_buffer_in: assert property (@(posedge CLOCK) disable iff (!RST_N)
    SETTINGS.osc_buffer_in == !SETTINGS.osc_on)
    else $error("buffer input mode mismatch");

  a_delay_enable: assert property (@(posedge CLOCK) disable iff (!RST_N)
    SETTINGS.high_pump_enabled == |SETTINGS.high_pump_delay)
    else $error("pump enable not from delay");

  a_delay_first: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load && !stage[`PPDC_B_DLY_SEL]
      |=> SETTINGS.high_pump_delay == $past(stage[`PPDC_B_DLY1_LO +: 2]))
    else $error("first delay register not used");

  a_delay_second: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load && stage[`PPDC_B_DLY_SEL]
      |=> SETTINGS.high_pump_delay == $past(stage[`PPDC_B_DLY2_LO +: 2]))
    else $error("second delay register not used");

  a_select_bit: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load |=> SETTINGS.high_pump_delay_select == $past(stage[`PPDC_B_DLY_SEL]))
    else $error("delay select mismatch");

  a_read_answer: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_read_req |=> WB_ACK_O)
    else $error("read not answered");

  a_write_answer: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_write_req |=> WB_ACK_O)
    else $error("write not answered");

  a_ctrl_reads: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_read_req ##0 (idx == `PPDC_IDX_CTRL) |=> WB_DAT_O == 32'h0)
    else $error("control word read not zero");

  a_status_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_read_req ##0 (idx == `PPDC_IDX_STATUS)
      |=> WB_DAT_O == {29'h0, $past(loaded), $past(change_seen), $past(PUMP_HIGH)})
    else $error("status read mismatch");

  a_unmapped_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_read_req ##0 (!hit_word && idx != `PPDC_IDX_CTRL && idx != `PPDC_IDX_STATUS)
      |=> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");

  a_word_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_read_req ##0 hit_word
      |=> WB_DAT_O == $past(stage[idx[2:0]*32 +: 32]))
    else $error("staging word read mismatch");

  a_loaded_set: assert property (@(posedge CLOCK) disable iff (!RST_N)
    load |=> loaded)
    else $error("loaded flag not set");

  a_loaded_hold: assert property (@(posedge CLOCK) disable iff (!RST_N)
    loaded |=> loaded)
    else $error("loaded flag cleared");

  a_change_high: assert property (@(posedge CLOCK) disable iff (!RST_N)
    FREQ_CHANGE |=> change_seen)
    else $error("change flag not set");

  a_change_low: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !FREQ_CHANGE |=> !change_seen)
    else $error("change flag not cleared");

  a_stage_quiet: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !wr_take |=> $stable(stage))
    else $error("staging word changed without write");

  a_ctrl_no_stage: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_take && !hit_word |=> $stable(stage))
    else $error("staging word changed by other write");

  a_no_ack_idle: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !req |=> !WB_ACK_O)
    else $error("ack without request");

  a_sel_refused: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_take && idx == `PPDC_IDX_CTRL && !WB_SEL_I[0] |=> $stable(SETTINGS))
    else $error("take over without byte lane");

  a_bit_refused: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_take && idx == `PPDC_IDX_CTRL && !WB_DAT_I[`PPDC_CTRL_LOAD] |=> $stable(SETTINGS))
    else $error("take over without load bit");

endmodule

//--- dv/ppdc_host_model.sv
// Host model: Wishbone classic master loading the control word.
// Assumes ppdc_cfg.svh on the include path and calls made just after a rising edge.
`timescale 1ns/100ps
`include "ppdc_cfg.svh"

module ppdc_host_model (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  output      logic        cyc,
  output      logic        stb,
  output      logic        we,
  output      logic [7:0]  adr,
  output      logic [3:0]  sel,
  output      logic [31:0] wdat
);
  import ppdc_pkg::*;

  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  initial begin
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    adr  = 8'h00;
    sel  = 4'h0;
    wdat = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdata;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    wdat <= ~d;
    @(posedge clk);
  endtask

  // Whole word staged before any take over
  task automatic stage(input ppdc_word_t w);
    logic [31:0] q;
    for (int k = 0; k < `PPDC_NUM_WORDS; k++) begin
      xfer(1'b1, 8'(k * 4), w[k*32 +: 32], 4'hf, q);
    end
  endtask
endmodule

//--- dv/pll_pump_dac_control_test.sv
// Testbench: loads control words and checks decoded settings and pump levels.
// Assumes ppdc_top with a 40 MHz clock and the host model as bus master.
`timescale 1ns/100ps
`include "ppdc_cfg.svh"

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module pll_pump_dac_control_test;
  import ppdc_pkg::*;

  logic        CLOCK;
  logic        RST_N;
  logic        FREQ_CHANGE;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [31:0] q;
  ppdc_cfg_s   SETTINGS;
  ppdc_cfg_s   prev;
  ppdc_word_t  w;
  logic [2:0]  b;
  logic        PUMP_HIGH;
  logic        PUMP_LOW;
  int          failures;
  int          tests_run;

  // ------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------
  ppdc_top i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .FREQ_CHANGE(FREQ_CHANGE), .SETTINGS(SETTINGS),
    .PUMP_HIGH(PUMP_HIGH), .PUMP_LOW(PUMP_LOW));

  ppdc_host_model i_host (.clk(CLOCK), .ack(ack), .rdata(rdat), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .wdat(wdat));

  // ------------------------------------------------------------
  // Expected decode
  // ------------------------------------------------------------
  function automatic ppdc_cfg_s exp_cfg(input ppdc_word_t v);
    ppdc_cfg_s c;
    logic      g;
    g = !v[144] && !v[32];
    c.wire_spur_switch        = v[60] & g;
    c.impulse_spur_correction = v[61] & g;
    c.high_pump_2ma           = v[62];
    c.low_pump_100ua          = v[63];
    c.high_pump_delay_select  = v[18];
    c.high_pump_delay         = v[18] ? v[23:22] : v[21:20];
    c.high_pump_enabled       = |c.high_pump_delay;
    c.osc_on                  = v[65];
    c.osc_buffer_out          = v[65] & v[64];
    c.osc_buffer_in           = !v[65];
    c.am_loop_filter_ext      = !v[65];
    c.align_dac_a_gain        = v[45:38];
    c.align_dac_a_offset      = v[30:24];
    c.align_dac_b_gain        = v[73:66];
    c.align_dac_b_offset      = v[58:52];
    return c;
  endfunction

  task automatic complete_run();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  initial begin
    repeat (20000) @(posedge CLOCK);
    failures++;
    complete_run();
  end

  initial begin
    failures = 0;
    tests_run = 0;
    RST_N = 1'b0;
    FREQ_CHANGE = 1'b0;
    repeat (5) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    prev = exp_cfg('0);
    `CHK("reset cfg", prev, SETTINGS)
    `CHK("reset low", 1'b1, PUMP_LOW)
    for (int i = 0; i < 8; i++) begin
      b = 3'(i);
      w = '0;
      w[144] = b[0];
      w[32] = b[1];
      w[61:60] = 2'h3;
      w[62] = b[0];
      w[63] = b[1];
      w[18] = b[2];
      w[23:20] = 4'(i * 5);
      w[65] = b[0] ^ b[1];
      w[64] = b[2];
      w[45:38] = 8'hff >> i;
      w[73:66] = 8'(i * 36);
      w[30:24] = 7'h7f >> i;
      w[58:52] = 7'(i * 16);
      i_host.stage(w);
      i_host.xfer(1'b1, `PPDC_OFF_CTRL, 32'h0, 4'hf, q);
      `CHK("held cfg", prev, SETTINGS)
      i_host.xfer(1'b1, `PPDC_OFF_CTRL, 32'h1, 4'h1, q);
      prev = exp_cfg(w);
      `CHK("cfg", prev, SETTINGS)
      FREQ_CHANGE <= 1'b1;
      repeat (2) @(posedge CLOCK);
      `CHK("pump high", prev.high_pump_enabled, PUMP_HIGH)
      `CHK("pump low", !prev.high_pump_enabled, PUMP_LOW)
      FREQ_CHANGE <= 1'b0;
      repeat (2) @(posedge CLOCK);
      `CHK("pump settled", 1'b1, PUMP_LOW)
    end
    i_host.xfer(1'b1, `PPDC_OFF_CTRL, 32'h1, 4'he, q);
    `CHK("sel refused", prev, SETTINGS)
    i_host.xfer(1'b0, `PPDC_OFF_STATUS, 32'h0, 4'hf, q);
    `CHK("status", 32'h4, q)
    i_host.xfer(1'b0, 8'h04, 32'h0, 4'hf, q);
    `CHK("stage read", w[63:32], q)
    i_host.xfer(1'b1, 8'h40, 32'hffff_ffff, 4'hf, q);
    i_host.xfer(1'b0, 8'h40, 32'h0, 4'hf, q);
    `CHK("unmapped", 32'h0, q)
    complete_run();
  end
endmodule
